/* File: hdl/ext_mem_seq_regs.svh */
// Constants for the external memory access cycle sequencer.
`ifndef EXT_MEM_SEQ_REGS_SVH
`define EXT_MEM_SEQ_REGS_SVH

// ---------------------------------------------------------------
// Transfer size encodings
// ---------------------------------------------------------------
`define XMS_SIZE_BYTE 2'h0
`define XMS_SIZE_HALF 2'h1
`define XMS_SIZE_WORD 2'h2

// ---------------------------------------------------------------
// Device access counts
// ---------------------------------------------------------------
`define XMS_ACC_1 3'h1
`define XMS_ACC_2 3'h2
`define XMS_ACC_4 3'h4

// ---------------------------------------------------------------
// Cycle totals with zero latency, by accesses per transfer
// ---------------------------------------------------------------
`define XMS_T_SYNC_RD_1 7'h04
`define XMS_T_SYNC_RD_2 7'h05
`define XMS_T_SYNC_RD_4 7'h07
`define XMS_T_SYNC_WR_1 7'h03
`define XMS_T_SYNC_WR_2 7'h04
`define XMS_T_SYNC_WR_4 7'h06
`define XMS_T_ASYNC_1 7'h03
`define XMS_T_ASYNC_2 7'h05
`define XMS_T_ASYNC_4 7'h08

// ---------------------------------------------------------------
// Chip select levels
// ---------------------------------------------------------------
`define XMS_CS_IDLE_N 2'h3

`endif

/* File: hdl/ext_mem_seq_pkg.sv */
// Types shared by the external memory access cycle sequencer.
package ext_mem_seq_pkg;

   // Sequencer states, one-hot.
   typedef enum logic [2:0]
   {
      SEQ_IDLE = 3'h1,
      SEQ_BUSY = 3'h2,
      SEQ_TURN = 3'h4
   } seq_state_e;

   // Transfer size field.
   typedef logic [1:0] xfer_size_t;

   // Cycle total field.
   typedef logic [6:0] cycle_count_t;

endpackage

/* File: hdl/ext_mem_cycle_budget.sv */
// Cycle budget lookup for one transfer of the external memory sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "ext_mem_seq_regs.svh"

module ext_mem_cycle_budget
(
   // Transfer description
   input wire logic [1:0] size_in,
   input wire logic write_in,
   // Device configuration
   input wire logic half_port_in,
   input wire logic sync_in,
   input wire logic [3:0] latency_in,
   // Budget
   output logic [2:0] accesses_out,
   output logic [6:0] total_out
);

   // ---------------------------------------------------------------
   // Access count
   // ---------------------------------------------------------------

   // A narrower port means more device accesses per transfer.
   wire is_word = (size_in == `XMS_SIZE_WORD);
   wire is_half = (size_in == `XMS_SIZE_HALF);
   wire four_acc = !half_port_in && is_word;
   wire two_acc = (!half_port_in && is_half) || (half_port_in && is_word);
   assign accesses_out = four_acc ? `XMS_ACC_4 :
                         two_acc ? `XMS_ACC_2 : `XMS_ACC_1;

   // ---------------------------------------------------------------
   // Cycle totals
   // ---------------------------------------------------------------

   // Synchronous read totals already carry one pipeline cycle per transfer.
   wire [6:0] sync_rd = four_acc ? `XMS_T_SYNC_RD_4 :
                        two_acc ? `XMS_T_SYNC_RD_2 : `XMS_T_SYNC_RD_1;
   wire [6:0] sync_wr = four_acc ? `XMS_T_SYNC_WR_4 :
                        two_acc ? `XMS_T_SYNC_WR_2 : `XMS_T_SYNC_WR_1;
   // Asynchronous totals spend two cycles per address phase.
   wire [6:0] async_t = four_acc ? `XMS_T_ASYNC_4 :
                        two_acc ? `XMS_T_ASYNC_2 : `XMS_T_ASYNC_1;
   wire [6:0] base_t = sync_in ? (write_in ? sync_wr : sync_rd) :
                       async_t;

   // Each latency step stretches every device access by one cycle.
   wire [6:0] lat_extra = {3'h0, latency_in} * {4'h0, accesses_out};
   assign total_out = base_t + lat_extra;

endmodule
`default_nettype wire

/* File: hdl/ext_mem_access_cycle_sequencer.sv */
// External memory access cycle sequencer: bus transfers to device accesses.
`timescale 1ns/10ps
`default_nettype none
`include "ext_mem_seq_regs.svh"

module ext_mem_access_cycle_sequencer
#(
   parameter int ADDR_W = 26
)
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // On-chip bus slave side
   input wire logic sel_in,
   input wire logic trans_in,
   input wire logic [ADDR_W:0] addr_in,
   input wire logic [1:0] size_in,
   input wire logic write_in,
   input wire logic [31:0] wdata_in,
   output logic ready_out,
   output logic [31:0] rdata_out,
   // Per chip select configuration
   input wire logic [1:0] device_port_width_sel_in,
   input wire logic [1:0] device_sync_in,
   input wire logic [3:0] cs0_latency_in,
   input wire logic [3:0] cs1_latency_in,
   // External device side
   output logic [ADDR_W-1:0] ext_addr_out,
   output logic [1:0] ext_cs_n_out,
   output logic ext_rw_n_out,
   output logic [1:0] ext_byte_en_out,
   output logic [15:0] ext_wdata_out,
   output logic ext_data_oe_out,
   input wire logic [15:0] ext_rdata_in
);

   // The address adder and lane math need at least a word of space.
   if (ADDR_W < 4)
   begin : g_bad_width
      $error("ADDR_W too small");
   end

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   // Reset asserts at once and releases two edges later.
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ---------------------------------------------------------------
   // Request decode
   // ---------------------------------------------------------------
   ext_mem_seq_pkg::seq_state_e state;
   ext_mem_seq_pkg::seq_state_e next_state;
   ext_mem_seq_pkg::cycle_count_t remain;
   logic cur_sync, cur_half, cur_write, cur_cs, first;
   logic [1:0] cur_size;
   logic [ADDR_W-1:0] cur_base;
   logic [2:0] cur_count, sub;
   logic [4:0] cur_plen, pcnt;
   logic [31:0] wword;
   logic cap1_v, cap2_v;
   logic [1:0] cap1_l, cap2_l;
   logic [2:0] req_count;
   logic [6:0] req_total;

   // The top address bit picks the chip select and its settings.
   wire req = sel_in && trans_in;
   wire req_cs = addr_in[ADDR_W];
   wire req_half = device_port_width_sel_in[req_cs];
   wire req_sync = device_sync_in[req_cs];
   wire [3:0] req_lat = req_cs ? cs1_latency_in : cs0_latency_in;
   wire [ADDR_W-1:0] req_mask = (size_in == `XMS_SIZE_WORD) ? ADDR_W'(3) :
                                (size_in == `XMS_SIZE_HALF) ? ADDR_W'(1) :
                                ADDR_W'(0);
   wire [ADDR_W-1:0] req_base = addr_in[ADDR_W-1:0] & ~req_mask;

   ext_mem_cycle_budget u_budget
   (
      .size_in(size_in),
      .write_in(write_in),
      .half_port_in(req_half),
      .sync_in(req_sync),
      .latency_in(req_lat),
      .accesses_out(req_count),
      .total_out(req_total)
   );

   // ---------------------------------------------------------------
   // Handshake and sequencing
   // ---------------------------------------------------------------

   // The ready cycle doubles as the next address phase; a change of
   // device type holds ready low one more cycle instead.
   wire in_busy = (state == ext_mem_seq_pkg::SEQ_BUSY);
   wire in_turn = (state == ext_mem_seq_pkg::SEQ_TURN);
   wire last = in_busy && (remain == 7'h01);
   wire need_turn = req && (req_sync != cur_sync);
   assign ready_out = (state == ext_mem_seq_pkg::SEQ_IDLE) || in_turn ||
                      (last && !need_turn);
   wire take = req && ready_out;
   wire take_rd = take && !write_in;

   // Reads start their first device access in the address phase; writes
   // wait one cycle for the bus write data.
   wire sub_active = in_busy && (sub < cur_count);
   wire sub_done = (pcnt == (cur_plen - 5'h01));
   wire emit = take_rd || sub_active;
   wire emit_last = take_rd ? (req_lat == 4'h0) : (sub_active && sub_done);

   // Next state: overlap goes straight to busy without idle.
   always_comb
   begin
      next_state = state;
      if (take)
         next_state = ext_mem_seq_pkg::SEQ_BUSY;
      else if (last && need_turn)
         next_state = ext_mem_seq_pkg::SEQ_TURN;
      else if (last || in_turn)
         next_state = ext_mem_seq_pkg::SEQ_IDLE;
   end

   // State and cycle budget; remain reaches one in the ready cycle.
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ext_mem_seq_pkg::SEQ_IDLE;
         remain <= 7'h00;
      end
      else
      begin
         state <= next_state;
         if (take)
            remain <= req_total - 7'h01;
         else if (in_busy && remain > 7'h01)
            remain <= remain - 7'h01;
      end
   end

   // Transfer fields latched in the address phase.
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {cur_sync, cur_half, cur_write, cur_cs} <= 4'h0;
         cur_size <= 2'h0;
         cur_base <= '0;
         cur_count <= 3'h0;
         cur_plen <= 5'h01;
      end
      else if (take)
      begin
         {cur_sync, cur_half, cur_write, cur_cs} <=
            {req_sync, req_half, write_in, req_cs};
         cur_size <= size_in;
         cur_base <= req_base;
         cur_count <= req_count;
         cur_plen <= {1'b0, req_lat} + 5'h01;
      end
   end

   // Sub-access index and the cycle within its phase.
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sub <= 3'h0;
         pcnt <= 5'h00;
      end
      else if (take)
      begin
         sub <= (take_rd && req_lat == 4'h0) ? 3'h1 : 3'h0;
         pcnt <= (take_rd && req_lat != 4'h0) ? 5'h01 : 5'h00;
      end
      else if (sub_active && sub_done)
      begin
         sub <= sub + 3'h1;
         pcnt <= 5'h00;
      end
      else if (sub_active)
         pcnt <= pcnt + 5'h01;
   end

   // ---------------------------------------------------------------
   // Device access fields
   // ---------------------------------------------------------------

   // Fields come from the request while a read is taken, else the latch.
   wire [2:0] e_idx = take_rd ? 3'h0 : sub;
   wire e_half = take_rd ? req_half : cur_half;
   wire e_cs = take_rd ? req_cs : cur_cs;
   wire e_write = take_rd ? 1'b0 : cur_write;
   wire [1:0] e_size = take_rd ? size_in : cur_size;
   wire [ADDR_W-1:0] e_base = take_rd ? req_base : cur_base;
   wire [ADDR_W-1:0] idx_w = {{(ADDR_W-3){1'b0}}, e_idx};
   wire [ADDR_W-1:0] step = e_half ? {idx_w[ADDR_W-2:0], 1'b0} : idx_w;
   wire [ADDR_W-1:0] emit_addr = e_base + step;
   wire [1:0] lane = e_base[1:0] + step[1:0];
   wire [1:0] emit_be = !e_half ? 2'h1 :
                        (e_size != `XMS_SIZE_BYTE) ? 2'h3 :
                        (e_base[0] ? 2'h2 : 2'h1);
   wire [1:0] emit_cs_n = emit ? ~(2'h1 << e_cs) : `XMS_CS_IDLE_N;
   wire [31:0] wsrc = first ? wdata_in : wword;
   wire [31:0] wshift = wsrc >> {lane, 3'h0};
   wire [15:0] emit_wdata = e_half ? (lane[1] ? wsrc[31:16] : wsrc[15:0]) :
                            {8'h00, wshift[7:0]};

   // Device pins are registered so that they change on clean edges.
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_addr_out <= '0;
         ext_cs_n_out <= `XMS_CS_IDLE_N;
         ext_rw_n_out <= 1'b1;
         ext_byte_en_out <= 2'h0;
         ext_wdata_out <= 16'h0000;
         ext_data_oe_out <= 1'b0;
      end
      else
      begin
         ext_addr_out <= emit ? emit_addr : ext_addr_out;
         ext_cs_n_out <= emit_cs_n;
         ext_rw_n_out <= !(emit && e_write);
         ext_byte_en_out <= emit ? emit_be : 2'h0;
         ext_wdata_out <= emit ? emit_wdata : ext_wdata_out;
         ext_data_oe_out <= emit && e_write;
      end
   end

   // Write data is sampled in the first data phase cycle.
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         first <= 1'b0;
         wword <= 32'h00000000;
      end
      else
      begin
         first <= take;
         wword <= first ? wdata_in : wword;
      end
   end

   // ---------------------------------------------------------------
   // Read capture
   // ---------------------------------------------------------------

   // Capture follows the pin register; a synchronous device needs one
   // more stage for its pipeline.
   wire cap_v = (cur_sync ? cap2_v : cap1_v) && !cur_write;
   wire [1:0] cap_l = cur_sync ? cap2_l : cap1_l;

   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {cap1_v, cap2_v} <= 2'h0;
         {cap1_l, cap2_l} <= 4'h0;
      end
      else
      begin
         cap1_v <= emit && emit_last && !e_write;
         cap1_l <= lane;
         cap2_v <= cap1_v;
         cap2_l <= cap1_l;
      end
   end

   // Each bus byte lane loads from the device lane that carries it.
   for (genvar g = 0; g < 4; g++)
   begin : g_lane
      wire [1:0] gl = 2'(g);
      wire hit = cur_half ? (cap_l[1] == gl[1]) : (cap_l == gl);
      wire [7:0] src = (cur_half && gl[0]) ? ext_rdata_in[15:8] :
                       ext_rdata_in[7:0];
      always_ff @(posedge clock_in or negedge rst_n)
      begin
         if (!rst_n)
            rdata_out[8*g +: 8] <= 8'h00;
         else if (cap_v && hit)
            rdata_out[8*g +: 8] <= src;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n);

   a_split_byte_port: assert property (
      take && !req_half && size_in == `XMS_SIZE_WORD |=> cur_count == 3'h4)
      else $error("word on byte port not split in four");
   a_phase_half: assert property (
      take && req_half && size_in != `XMS_SIZE_WORD |=> cur_count == 3'h1)
      else $error("halfword port access count wrong");
   a_addr_ascend: assert property (
      sub_active && !take && $past(sub_active) && sub != $past(sub)
      |-> emit_addr == $past(emit_addr) + (cur_half ? ADDR_W'(2) : ADDR_W'(1)))
      else $error("split access address did not step");
   a_latency_hold: assert property (
      sub_active && !take && !sub_done |=> sub == $past(sub))
      else $error("phase ended before its latency");
   a_total_load: assert property (
      take |=> remain == $past(req_total) - 7'h01)
      else $error("cycle budget not loaded");
   // The fourth cycle is the ready cycle, unless a turnaround holds it.
   a_sync_read_min: assert property (
      take && req_sync && !write_in && req_lat == 4'h0 && req_count == 3'h1
      |=> remain == 7'h03 ##2 (last && (ready_out || need_turn)))
      else $error("sync single read not four cycles");
   a_async_word: assert property (
      take && !req_sync && !req_half && size_in == `XMS_SIZE_WORD &&
      req_lat == 4'h0 |=> remain == 7'h07)
      else $error("async word on byte port not eight cycles");
   a_async_two: assert property (
      take && !req_sync |=> ({1'b0, remain} + 8'h01) >= {4'h0, cur_count, 1'b0})
      else $error("async access shorter than two per phase");
   a_no_idle: assert property (
      take && state != ext_mem_seq_pkg::SEQ_IDLE
      |=> state == ext_mem_seq_pkg::SEQ_BUSY)
      else $error("back-to-back transfer went idle");
   a_turn_insert: assert property (
      last && need_turn |-> !ready_out ##1 in_turn && ready_out)
      else $error("turnaround cycle missing");
   // The pins are quiet in the turnaround cycle itself; a read taken there
   // may already drive them in the cycle after.
   a_turn_quiet: assert property (
      in_turn |-> ext_cs_n_out == `XMS_CS_IDLE_N && ext_rw_n_out)
      else $error("device controls active in turnaround");
   a_sub_ascend: assert property (
      in_busy && !$past(take) && sub != $past(sub) |-> sub == $past(sub) + 3'h1)
      else $error("sub-access order not ascending");

   c_split_four: cover property (take && req_count == 3'h4);
   c_back_to_back: cover property (take && in_busy);
   c_turnaround: cover property (in_turn ##0 take);
   c_latency: cover property (take && req_lat != 4'h0 ##1 sub_active[*3]);

endmodule
`default_nettype wire

/* File: verification/ext_mem_device_model.sv */
// Behavioural model of the byte and halfword memories on the device pins.
`timescale 1ns/10ps
`default_nettype none

module ext_mem_device_model
(
   // Clock
   input wire logic clock_in,
   // Device pins driven by the sequencer
   input wire logic [7:0] addr_in,
   input wire logic [1:0] cs_n_in,
   input wire logic rw_n_in,
   input wire logic [1:0] byte_en_in,
   input wire logic [15:0] wdata_in,
   input wire logic data_oe_in,
   // Per chip select device setup
   input wire logic [1:0] half_port_in,
   input wire logic [1:0] sync_in,
   // Read data back to the sequencer
   output logic [15:0] rdata_out
);
   logic [7:0] mem [0:511];
   logic [15:0] noise = 16'hC35A;
   logic [15:0] held = 16'h0;
   logic held_ok = 1'b0;
   logic sel;
   logic idx;
   logic [15:0] word_now;
   logic [8:0] lo;

   // Decode the selected device and the word it presents right now.
   assign sel = (cs_n_in == 2'h2) || (cs_n_in == 2'h1);
   assign idx = (cs_n_in == 2'h1);
   assign lo = half_port_in[idx] ? {idx, addr_in[7:1], 1'b0} : {idx, addr_in};
   assign word_now = half_port_in[idx] ? {mem[lo + 9'h1], mem[lo]} :
      {noise[15:8], mem[lo]};

   // Both memories start from a known pattern that the bench also keeps.
   initial
   begin
      for (int i = 0; i < 512; i++)
         mem[i] = 8'(i * 29 + 91);
   end

   // A synchronous part answers one cycle late; writes land on the edge.
   always @(posedge clock_in)
   begin
      noise <= noise + 16'h3B5D;
      held_ok <= sel && rw_n_in && sync_in[idx];
      held <= word_now;
      if (sel && !rw_n_in && data_oe_in && byte_en_in[0])
         mem[lo] <= wdata_in[7:0];
      if (sel && !rw_n_in && data_oe_in && byte_en_in[1])
         mem[lo + 9'h1] <= wdata_in[15:8];
   end

   // Released lines show a changing pattern, never the last value.
   assign rdata_out = (sel && rw_n_in && !sync_in[idx]) ? word_now :
      held_ok ? held : noise;
endmodule

`default_nettype wire

/* File: verification/ext_mem_access_cycle_sequencer_tb.sv */
// Self-checking bench for the external memory access cycle sequencer.
`timescale 1ns/10ps
`default_nettype none

module ext_mem_access_cycle_sequencer_tb;
   localparam int ADDR_W = 26;
   localparam int T_SR[3] = '{4, 5, 7};
   localparam int T_SW[3] = '{3, 4, 6};
   localparam int T_AS[3] = '{3, 5, 8};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sel = 1'b0;
   logic trans = 1'b0;
   logic [ADDR_W:0] addr = '0;
   logic [1:0] size = 2'h0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [1:0] port = 2'h0;
   logic [1:0] sync = 2'h0;
   logic [3:0] lat0 = 4'h0;
   logic [3:0] lat1 = 4'h0;
   logic ready;
   logic [31:0] rdata;
   logic [ADDR_W-1:0] ext_addr;
   logic [1:0] cs_n;
   logic [1:0] be;
   logic rw_n;
   logic oe;
   logic [15:0] ext_wd;
   logic [15:0] ext_rd;
   int failures = 0;
   int checked = 0;
   int seed = 99;
   logic [7:0] bmem [0:511];
   logic [7:0] seen [$];
   int it_cs [4];
   int it_sz [4];
   int it_wr [4];
   logic [7:0] it_ad [4];
   logic [31:0] it_wd [4];

   // 10 MHz clock.
   always #50 clk = ~clk;

   // --------
   // Design and device
   // --------
   ext_mem_access_cycle_sequencer #(.ADDR_W(ADDR_W)) u_dut
   (
      .clock_in(clk), .rst_n_in(rst_n), .sel_in(sel), .trans_in(trans),
      .addr_in(addr), .size_in(size), .write_in(wr), .wdata_in(wdata),
      .ready_out(ready), .rdata_out(rdata),
      .device_port_width_sel_in(port), .device_sync_in(sync),
      .cs0_latency_in(lat0), .cs1_latency_in(lat1),
      .ext_addr_out(ext_addr), .ext_cs_n_out(cs_n), .ext_rw_n_out(rw_n),
      .ext_byte_en_out(be), .ext_wdata_out(ext_wd),
      .ext_data_oe_out(oe), .ext_rdata_in(ext_rd)
   );

   ext_mem_device_model u_mem
   (
      .clock_in(clk), .addr_in(ext_addr[7:0]), .cs_n_in(cs_n),
      .rw_n_in(rw_n), .byte_en_in(be), .wdata_in(ext_wd),
      .data_oe_in(oe), .half_port_in(port), .sync_in(sync),
      .rdata_out(ext_rd)
   );

   // Log each distinct device address while a chip select is low.
   always @(negedge clk)
   begin
      if (cs_n != 2'h3 && (seen.size() == 0 || seen[$] != ext_addr[7:0]))
         seen.push_back(ext_addr[7:0]);
   end

   // --------
   // Reference model and checks
   // --------
   function automatic int n_acc(logic hp, int sz);
      return hp ? ((sz == 2) ? 2 : 1) : (1 << sz);
   endfunction

   // Each device access stretched by latency costs that many extra cycles.
   function automatic int t_total(logic sy, logic hp, int sz, int w, int lat);
      int k;
      k = (n_acc(hp, sz) == 4) ? 2 : n_acc(hp, sz) - 1;
      return (sy ? (w ? T_SW[k] : T_SR[k]) : T_AS[k]) + lat * n_acc(hp, sz);
   endfunction

   function automatic logic [31:0] lanes(int sz, logic [7:0] ad);
      if (sz == 2)
         return 32'hFFFFFFFF;
      return (sz == 1) ? 32'hFFFF << (16 * ad[1]) : 32'hFF << (8 * ad[1:0]);
   endfunction

   task automatic cmp_num(int got, int exp);
      checked++;
      if (got != exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t count %0d exp %0d", $time, got, exp);
      end
   endtask

   task automatic cmp_data(logic [31:0] got, logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t data %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_addr(logic [7:0] got, logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t address %h exp %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      if (failures == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Issue n transfers back to back; each is presented in the ready cycle
   // of the one before, so overlap and turnaround both show in the total.
   task automatic run_batch(int n);
      int cyc, ex, w, c, k, st;
      logic [31:0] m;
      logic [31:0] e;
      logic [7:0] b;
      cyc = 0;
      ex = 0;
      seen.delete();
      for (int i = 0; i <= n; i++)
      begin
         @(posedge clk);
         if (i > 0)
         begin
            wdata <= it_wd[i - 1];
            m = lanes(it_sz[i - 1], it_ad[i - 1]);
            b = it_ad[i - 1] & 8'hFC;
            for (int l = 0; l < 4; l++)
               if (it_wr[i - 1] != 0 && m[8 * l] === 1'b1)
                  bmem[{1'(it_cs[i - 1]), 8'(b + l)}] = it_wd[i - 1][8 * l +: 8];
         end
         if (i < n)
         begin
            c = it_cs[i];
            ex += t_total(sync[c], port[c], it_sz[i], it_wr[i], c ? lat1 : lat0);
            ex -= (i > 0 && sync[c] == sync[it_cs[i - 1]]) ? 1 : 0;
            sel <= 1'b1;
            trans <= 1'b1;
            addr <= {1'(c), 18'($random(seed)), it_ad[i]};
            size <= 2'(it_sz[i]);
            wr <= 1'(it_wr[i]);
         end
         else
         begin
            trans <= 1'b0;
            sel <= 1'($random(seed));
         end
         w = 0;
         do
         begin
            @(negedge clk);
            w++;
         end
         while (ready !== 1'b1 && w < 150);
         cyc = (i == 0) ? 1 : cyc + w;
         cmp_num(w < 150, 1);
         if (i > 0 && it_wr[i - 1] == 0)
         begin
            m = lanes(it_sz[i - 1], it_ad[i - 1]);
            b = it_ad[i - 1] & 8'hFC;
            for (int l = 0; l < 4; l++)
               e[8 * l +: 8] = bmem[{1'(it_cs[i - 1]), 8'(b + l)}];
            cmp_data(rdata & m, e & m);
         end
      end
      cmp_num(cyc, ex);
      if (n == 1)
      begin
         repeat (2) @(negedge clk);
         c = it_cs[0];
         k = n_acc(port[c], it_sz[0]);
         st = port[c] ? 2 : 1;
         b = (it_sz[0] == 2) ? it_ad[0] & 8'hFC : it_ad[0];
         b = (it_sz[0] == 1) ? b & 8'hFE : b;
         m[7:0] = port[c] ? 8'hFE : 8'hFF;
         cmp_num(seen.size(), k);
         for (int j = 0; j < k && j < seen.size(); j++)
            cmp_addr(seen[j] & m[7:0], 8'(b + j * st) & m[7:0]);
      end
   endtask

   // --------
   // Sequence
   // --------
   initial
   begin
      int n;
      for (int i = 0; i < 512; i++)
         bmem[i] = 8'(i * 29 + 91);
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // Every port width and device kind, each size, write then read back.
      for (int cfg = 0; cfg < 4; cfg++)
      begin
         @(posedge clk);
         port <= (cfg % 2 == 1) ? 2'h3 : 2'h0;
         sync <= (cfg > 1) ? 2'h3 : 2'h0;
         for (int sz = 0; sz < 3; sz++)
            for (int w = 1; w >= 0; w--)
            begin
               it_cs[0] = (w == 1) ? ($random(seed) & 1) : it_cs[0];
               it_ad[0] = (w == 1) ? 8'($random(seed)) : it_ad[0];
               it_sz[0] = sz;
               it_wr[0] = w;
               it_wd[0] = $random(seed);
               run_batch(1);
            end
      end
      // Random batches over both chip selects, mixed kinds and latencies.
      repeat (300)
      begin
         @(posedge clk);
         port <= 2'($random(seed));
         sync <= 2'($random(seed));
         lat0 <= 4'($random(seed));
         lat1 <= 4'($random(seed));
         n = ($random(seed) & 3) + 1;
         for (int i = 0; i < n; i++)
         begin
            it_cs[i] = $random(seed) & 1;
            it_sz[i] = ($random(seed) & 32'h7FFFFFFF) % 3;
            it_wr[i] = $random(seed) & 1;
            it_ad[i] = 8'($random(seed)) & 8'h1F;
            it_wd[i] = $random(seed);
         end
         run_batch(n);
      end
      close_out();
   end

   // Watchdog well beyond the expected run length.
   initial
   begin
      repeat (60000) @(posedge clk);
      failures++;
      close_out();
   end
endmodule

`default_nettype wire
